// *** verilog/tdmfb_pkg.sv ***
// Purpose: shared constants and types of the tdm port unit frame buffer
// Assumes: 16-bit register port, 9-bit word address
// Notes:   offsets below 9'h100 reach the dsp-side frame buffer
`default_nettype none
package tdmfb_pkg;
	localparam int NUM_PORTS = 4;
	localparam int ADDR_W    = 9;
	localparam int DATA_W    = 16;

	// register port map
	localparam logic [8:0] OFS_TX_BLOCK = 9'h080;
	localparam logic [8:0] OFS_CTRL     = 9'h100;
	localparam logic [8:0] OFS_STATUS   = 9'h101;
	localparam logic [8:0] OFS_TSC_BASE = 9'h108;
	localparam int         TSC_REGS     = 8;
	localparam int         TSC_W        = 16;

	// control register fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_DBL_BIT   = 2;
	localparam int CTRL_HALF_BIT  = 3;
	localparam int CTRL_OWNER_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// status register fields
	localparam int STAT_SERBUF_BIT = 0;
	localparam int STAT_FRAME_BIT  = 1;
	localparam int STAT_OVF_BIT    = 2;
	localparam int STAT_SYNCED_BIT = 3;

	// last bit position of a frame per rate mode
	localparam logic [10:0] LAST_POS_4X = 11'h0ff;
	localparam logic [10:0] LAST_POS_2X = 11'h1ff;
	localparam logic [10:0] LAST_POS_1X = 11'h3ff;
	localparam logic [10:0] LAST_POS_HI = 11'h7ff;

	typedef enum logic [1:0] {
		MODE_4X2M  = 2'h0,
		MODE_2X4M  = 2'h1,
		MODE_1X8M  = 2'h2,
		MODE_1X16M = 2'h3
	} tdmfb_mode_e;

	typedef enum logic [1:0] {
		LINK_HUNT   = 2'b01,
		LINK_FRAMED = 2'b10
	} tdmfb_link_e;

	// one received slot event for all ports, waiting for a memory write
	typedef struct packed {
		logic             buf_sel;
		logic [3:0]       valid;
		logic [3:0][6:0]  addr;
		logic [3:0][7:0]  data;
	} tdmfb_rxword_s;

	typedef struct packed {
		logic [8:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} tdmfb_bus_s;
endpackage
`default_nettype wire

// *** verilog/tdmfb_unit.sv ***
// Purpose: tdm port unit, serial pcm ports to a swapped pair of frame buffers
// Assumes: ref_clk far faster than the link data clock; link pins are asynchronous
// Notes:   memory reads are combinational, bus read data appear one cycle later
//
// Behaviour
// - four ports, 128 rx and 128 tx slots
// - 4x2M, 2x4M, 1x8M with single or double clock
// - 1x16M single clock, selectable frame half
// - 16M mode stores only the selected half
// - per-slot per-port tristate drives port pin
// - pin owner select hands pins to hdlc
// - two buffers swap roles every frame
// - serial to parallel bytes and back
// - receive blocks placed per rate mode
// - transmit blocks placed per rate mode
// - unused ports idle with outputs tristated
// - single rate: drive rising, sample falling, sync
// - double rate: two clocks per bit
// - slots travel msb first
`timescale 1ns/1ns
`default_nettype none
module tdmfb_unit
	import tdmfb_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic               ref_clk,
	input  wire logic               srst,
	input  wire logic [8:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [15:0]        reg_rdata,
	input  wire logic               tdm_data_clock,
	input  wire logic               tdm_frame_sync,
	input  wire logic [3:0]         serial_rx_line,
	output logic      [3:0]         serial_tx_line_out,
	output logic      [3:0]         serial_tx_line_oe,
	output logic      [3:0]         slot_tristate_out,
	input  wire logic [3:0]         hdlc_tx_data,
	input  wire logic [3:0]         hdlc_tx_oe,
	output logic      [3:0]         hdlc_rx_line,
	output logic                    rx_overflow
);
	typedef struct packed {
		logic [1:0]                       clk_sy;
		logic                             clk_q;
		logic [1:0]                       fs_sy;
		logic                             fs_q;
		logic [3:0][1:0]                  rx_sy;
		tdmfb_link_e                      link;
		logic                             ser_buf;
		logic                             frame_tgl;
		logic [10:0]                      pos;
		logic                             phase;
		logic [3:0][7:0]                  rx_sh;
		logic [3:0]                       tx_line;
		logic [3:0]                       tx_oe;
		logic [4:0]                       ctrl;
		logic [127:0]                     tsc;
		logic [FIFO_DEPTH-1:0][64:0]      fifo_q;
		logic [1:0]                       fifo_cnt;
		logic                             ovf;
		logic [15:0]                      rdata;
	} tdmfb_state_s;

	tdmfb_state_s  s;
	tdmfb_state_s  next_s;
	// two frame buffers of 256 bytes: rx blocks low, tx blocks high
	// one array for both keeps the swap a single index bit
	logic [7:0]    mem [2][256];

	tdmfb_bus_s    bus;
	tdmfb_mode_e   mode;
	tdmfb_rxword_s push_word;
	tdmfb_rxword_s head;
	logic          dbl;
	logic          fall;
	logic          rise;
	logic          frame_start;
	logic          framed;
	logic          push;
	logic          pop;
	logic          drain_ready;
	logic          in_half;
	logic [7:0]    slot;
	logic [10:0]   last_pos;
	logic [6:0]    p_addr;
	logic [7:0]    tx_byte;
	logic [1:0]    cnt_tmp;

	// port index to block offset inside a 128-byte half
	function automatic logic [6:0] slot_addr(input tdmfb_mode_e m, input logic [1:0] p,
		input logic [7:0] sl);
		unique case (m)
			MODE_4X2M: slot_addr = {p, sl[4:0]};
			MODE_2X4M: slot_addr = {p[1], sl[5:0]};
			MODE_1X8M,
			MODE_1X16M: slot_addr = sl[6:0];
		endcase
	endfunction

	// which ports carry data in a given rate mode
	function automatic logic port_active(input tdmfb_mode_e m, input logic [1:0] p);
		unique case (m)
			MODE_4X2M: port_active = 1'b1;
			MODE_2X4M: port_active = ~p[0];
			MODE_1X8M,
			MODE_1X16M: port_active = (p == 2'h0);
		endcase
	endfunction

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign mode = tdmfb_mode_e'(s.ctrl[CTRL_MODE_LSB +: 2]);
	// double clocking is refused in the 16M mode
	assign dbl = s.ctrl[CTRL_DBL_BIT] & (mode != MODE_1X16M);

	// link edges are found on the second synchroniser stage only
	assign fall = s.clk_q & ~s.clk_sy[1];
	assign rise = ~s.clk_q & s.clk_sy[1];
	assign frame_start = fall & s.fs_sy[1] & ~s.fs_q;
	assign framed = (s.link == LINK_FRAMED);
	assign slot = s.pos[10:3];
	assign in_half = (mode != MODE_1X16M) | (slot[7] == s.ctrl[CTRL_HALF_BIT]);

	// the position counter wraps at the mode's bit count, so a missing sync
	// leaves the unit running on its own frame timing
	always_comb begin
		unique case (mode)
			MODE_4X2M: last_pos = LAST_POS_4X;
			MODE_2X4M: last_pos = LAST_POS_2X;
			MODE_1X8M: last_pos = LAST_POS_1X;
			MODE_1X16M: last_pos = LAST_POS_HI;
		endcase
	end

	// fifo head and drain: dsp buffer writes own the memory port first
	// a dsp write stalls the drain; the two-entry buffer absorbs that stall
	assign head = tdmfb_rxword_s'(s.fifo_q[0]);
	assign drain_ready = ~(bus.wr & ~bus.addr[8]);
	assign pop = (s.fifo_cnt != 2'h0) & drain_ready;

	// slot event collected when the last bit of a byte is sampled
	always_comb begin
		push_word = '0;
		push_word.buf_sel = s.ser_buf;
		for (int p = 0; p < NUM_PORTS; p++) begin
			push_word.addr[p]  = slot_addr(mode, 2'(p), slot);
			push_word.data[p]  = {s.rx_sh[p][6:0], s.rx_sy[p][1]};
			push_word.valid[p] = port_active(mode, 2'(p)) & in_half;
		end
	end

	// a slot event is lost only when the buffer is full, which needs far more
	// back-to-back dsp writes than one link bit time holds
	assign push = fall & framed & ~frame_start & (~dbl | s.phase) & (s.pos[2:0] == 3'h7);

	// next state of the whole unit
	always_comb begin
		next_s = s;
		p_addr = '0;
		tx_byte = '0;
		cnt_tmp = s.fifo_cnt;
		next_s.rdata = '0;

		// two-stage synchronisers, then one more stage for edge detection
		next_s.clk_sy = {s.clk_sy[0], tdm_data_clock};
		next_s.clk_q  = s.clk_sy[1];
		next_s.fs_sy  = {s.fs_sy[0], tdm_frame_sync};
		for (int p = 0; p < NUM_PORTS; p++) begin
			next_s.rx_sy[p] = {s.rx_sy[p][0], serial_rx_line[p]};
		end
		if (fall) begin
			next_s.fs_q = s.fs_sy[1];
		end

		// frame alignment and bit timing
		// nothing is sampled on the frame start edge itself; bit 7 of slot 0
		// is driven on the following rising edge
		if (frame_start) begin
			next_s.link      = LINK_FRAMED;
			next_s.ser_buf   = ~s.ser_buf;
			next_s.frame_tgl = ~s.frame_tgl;
			next_s.pos       = '0;
			next_s.phase     = 1'b0;
		end else if (fall && framed) begin
			if (!dbl || s.phase) begin
				for (int p = 0; p < NUM_PORTS; p++) begin
					next_s.rx_sh[p] = {s.rx_sh[p][6:0], s.rx_sy[p][1]};
				end
				next_s.pos = (s.pos == last_pos) ? 11'h000 : s.pos + 11'h001;
			end
			next_s.phase = dbl & ~s.phase;
		end

		// transmit: one bit per rising edge, or every second one in double rate
		// tx_oe stands until the next driving edge, so a tsc write reaches
		// the pin only from the next bit onward
		if (rise && framed && (!dbl || !s.phase)) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				p_addr = slot_addr(mode, 2'(p), slot);
				tx_byte = mem[s.ser_buf][{1'b1, p_addr}];
				next_s.tx_line[p] = tx_byte[3'h7 - s.pos[2:0]];
				next_s.tx_oe[p] = port_active(mode, 2'(p)) & in_half
					& s.tsc[p_addr];
			end
		end
		if (!framed) begin
			next_s.tx_oe = '0;
		end

		// two-entry buffer between the deserialiser and the frame memory
		if (pop) begin
			next_s.fifo_q[0] = s.fifo_q[FIFO_DEPTH-1];
			cnt_tmp = s.fifo_cnt - 2'h1;
		end
		if (push) begin
			if (cnt_tmp != 2'(FIFO_DEPTH)) begin
				next_s.fifo_q[cnt_tmp[0]] = push_word;
				cnt_tmp = cnt_tmp + 2'h1;
			end
		end
		next_s.fifo_cnt = cnt_tmp;

		// register writes; overflow clear happens before set so set wins
		if (bus.wr) begin
			if (bus.addr == OFS_CTRL) begin
				next_s.ctrl = bus.wdata[4:0];
			end else if (bus.addr == OFS_STATUS && bus.wdata[STAT_OVF_BIT]) begin
				next_s.ovf = 1'b0;
			end else if (bus.addr[8:3] == OFS_TSC_BASE[8:3]) begin
				next_s.tsc[{bus.addr[2:0], 4'h0} +: TSC_W] = bus.wdata;
			end
		end
		if (push && cnt_tmp == s.fifo_cnt && !pop) begin
			next_s.ovf = 1'b1;
		end

		// register reads, data valid only in the following cycle
		if (bus.rd) begin
			if (!bus.addr[8]) begin
				next_s.rdata = {8'h00, mem[~s.ser_buf][bus.addr[7:0]]};
			end else if (bus.addr == OFS_CTRL) begin
				next_s.rdata = {11'h000, s.ctrl};
			end else if (bus.addr == OFS_STATUS) begin
				next_s.rdata = {12'h000, framed, s.ovf, s.frame_tgl, s.ser_buf};
			end else if (bus.addr[8:3] == OFS_TSC_BASE[8:3]) begin
				next_s.rdata = s.tsc[{bus.addr[2:0], 4'h0} +: TSC_W];
			end
		end
	end

	// memory is not cleared by reset; the dsp fills its buffer before the
	// first frame start hands that buffer to the link
	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s <= '0;
			s.link <= LINK_HUNT;
			s.ctrl <= CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	// frame memory: dsp writes its buffer, drained slot events fill the serial one
	always_ff @(posedge ref_clk) begin
		if (bus.wr && !bus.addr[8]) begin
			mem[~s.ser_buf][bus.addr[7:0]] <= bus.wdata[7:0];
		end
		if (pop) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (head.valid[p]) begin
					mem[head.buf_sel][{1'b0, head.addr[p]}] <= head.data[p];
				end
			end
		end
	end

	// pin multiplexer between this unit and the hdlc unit
	// hdlc ownership hides the slot indicator, so outside logic never sees
	// stale slot enables while the hdlc unit drives the pins
	always_comb begin
		if (s.ctrl[CTRL_OWNER_BIT]) begin
			serial_tx_line_out = hdlc_tx_data;
			serial_tx_line_oe  = hdlc_tx_oe;
			slot_tristate_out  = 4'h0;
		end else begin
			serial_tx_line_out = s.tx_line;
			serial_tx_line_oe  = s.tx_oe;
			slot_tristate_out  = s.tx_oe;
		end
	end

	assign hdlc_rx_line = serial_rx_line;
	assign reg_rdata    = s.rdata;
	assign rx_overflow  = s.ovf;
endmodule
`default_nettype wire

// *** tb/tdmfb_unit_properties.sv ***
// Purpose: port checks of the tdm frame buffer unit
// Assumes: link clock far slower than ref_clk
// Notes:   hold checks skip spans that hold register writes
`timescale 1ns/1ns
`default_nettype none
module tdmfb_unit_properties (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic [8:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        tdm_data_clock,
	input wire logic [3:0]  serial_rx_line,
	input wire logic [3:0]  serial_tx_line_out,
	input wire logic [3:0]  serial_tx_line_oe,
	input wire logic [3:0]  slot_tristate_out,
	input wire logic [3:0]  hdlc_rx_line
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("rdata idle");
	property p_hi; $past(reg_rd) && $past(reg_addr) < 9'h100 |-> reg_rdata[15:8] == 8'h00; endproperty
	a_hi: assert property (p_hi) else $error("high byte");
	property p_unmap; $past(reg_rd) && $past(reg_addr) > 9'h10f |-> reg_rdata == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_hdlc; hdlc_rx_line == serial_rx_line; endproperty
	a_hdlc: assert property (p_hdlc) else $error("hdlc rx copy");
	property p_tri; slot_tristate_out != 4'h0 |-> serial_tx_line_oe == slot_tristate_out; endproperty
	a_tri: assert property (p_tri) else $error("tri vs oe");
	property p_rst; $past(srst) |-> serial_tx_line_oe == 4'h0 && reg_rdata == 16'h0000; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	// pins move only a few cycles after a link rising edge, never late in a half period
	property p_hold_hi; (tdm_data_clock && !reg_wr) [*8] |-> $stable(slot_tristate_out); endproperty
	a_hold_hi: assert property (p_hold_hi) else $error("tri moved");
	property p_hold_lo; (!tdm_data_clock && !reg_wr) [*8] |-> $stable(serial_tx_line_out & slot_tristate_out); endproperty
	a_hold_lo: assert property (p_hold_lo) else $error("tx moved");
endmodule
bind tdmfb_unit tdmfb_unit_properties u_props (
	.ref_clk            (ref_clk),
	.srst               (srst),
	.reg_addr           (reg_addr),
	.reg_wr             (reg_wr),
	.reg_rd             (reg_rd),
	.reg_rdata          (reg_rdata),
	.tdm_data_clock     (tdm_data_clock),
	.serial_rx_line     (serial_rx_line),
	.serial_tx_line_out (serial_tx_line_out),
	.serial_tx_line_oe  (serial_tx_line_oe),
	.slot_tristate_out  (slot_tristate_out),
	.hdlc_rx_line       (hdlc_rx_line)
);
`default_nettype wire

// *** tb/tdmfb_link_model.sv ***
// Purpose: far pcm highway device: clock, sync, rx lines, tx capture
// Assumes: port p slot s lives at offset (p*32+s) mod 128
// Notes:   clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module tdmfb_link_model (
	output logic            dclk,
	output logic            fsync,
	output logic      [3:0] rx,
	input  wire logic [3:0] tx,
	input  wire logic [3:0] oe
);
	logic [7:0] rx_mem [128];
	logic [7:0] tx_cap [128];
	logic       oe_cap [128];
	int         idle_bad;
	int         hsel;
	initial begin
		dclk = 1'b0;
		fsync = 1'b0;
		rx = 4'h0;
		idle_bad = 0;
		hsel = 0;
	end
	// link cycle without data; rx keeps changing so no stale bit looks valid
	task automatic cyc(input logic sy);
		dclk = 1'b1;
		fsync = sy;
		rx = ~rx;
		#40 dclk = 1'b0;
		#40;
	endtask
	// one frame of sp slots a port; dbl adds a second clock to each bit
	task automatic frame(input int sp, input int dbl);
		int s, n;
		logic act;
		#3;
		cyc(1'b0);
		cyc(1'b1);
		for (int b = 0; b < sp * 8 * (dbl + 1); b++) begin
			s = b / (dbl + 1);
			dclk = 1'b1;
			fsync = 1'b0;
			for (int p = 0; p < 4; p++) begin
				n = (p * 32 + s / 8) % 128;
				act = p % (sp / 32) == 0 && s / 1024 == hsel;
				rx[p] = act ? rx_mem[n][7 - s % 8] : ~rx[p];
			end
			#40 dclk = 1'b0;
			for (int p = 0; p < 4; p++) begin
				n = (p * 32 + s / 8) % 128;
				act = p % (sp / 32) == 0 && s / 1024 == hsel;
				if (b % (dbl + 1) == dbl && act) begin
					tx_cap[n][7 - s % 8] = tx[p];
					oe_cap[n] = oe[p];
				end
				if (!act && oe[p])
					idle_bad++;
			end
			#40;
		end
		cyc(1'b1);
	endtask
endmodule
`default_nettype wire

// *** tb/tb_tdmfb_unit.sv ***
// Purpose: self-checking bench of the tdm frame buffer unit
// Assumes: link model on the serial pins, 80 ns link clock
// Notes:   expected bytes live in bench arrays, never in the unit
`timescale 1ns/1ns
`default_nettype none
module tb_tdmfb_unit import tdmfb_pkg::*; ;
	logic        ref_clk, srst, reg_wr, reg_rd, tdm_data_clock, tdm_frame_sync, rx_overflow;
	logic [8:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_val;
	logic [3:0]  serial_rx_line, serial_tx_line_out, serial_tx_line_oe, slot_tristate_out;
	logic [3:0]  hdlc_tx_data, hdlc_tx_oe, hdlc_rx_line;
	logic [15:0] tsc [8];
	logic [7:0]  tx_exp [128];
	logic [31:0] seed = 32'h0000_003a;
	int          errors = 0;
	int          cmp_count = 0;
	tdmfb_unit dut (
		.ref_clk            (ref_clk),
		.srst               (srst),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.tdm_data_clock     (tdm_data_clock),
		.tdm_frame_sync     (tdm_frame_sync),
		.serial_rx_line     (serial_rx_line),
		.serial_tx_line_out (serial_tx_line_out),
		.serial_tx_line_oe  (serial_tx_line_oe),
		.slot_tristate_out  (slot_tristate_out),
		.hdlc_tx_data       (hdlc_tx_data),
		.hdlc_tx_oe         (hdlc_tx_oe),
		.hdlc_rx_line       (hdlc_rx_line),
		.rx_overflow        (rx_overflow)
	);
	tdmfb_link_model link (.dclk(tdm_data_clock), .fsync(tdm_frame_sync), .rx(serial_rx_line),
		.tx(serial_tx_line_out), .oe(serial_tx_line_oe));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// fill dsp buffer and slot enables, run one frame, then read what arrived
	// mode carries the half select in bit 3 for the 16M mode
	task automatic run_mode(input int mode, input int dbl, input int sp);
		link.hsel = (mode >> 3) & 1;
		wr(OFS_CTRL, 16'(mode + dbl * 4));
		for (int k = 0; k < 8; k++) begin
			tsc[k] = 16'(xs());
			wr(OFS_TSC_BASE + 9'(k), tsc[k]);
		end
		for (int i = 0; i < 128; i++) begin
			tx_exp[i] = 8'(xs());
			link.rx_mem[i] = 8'(xs());
			wr(OFS_TX_BLOCK + 9'(i), {8'(xs()), tx_exp[i]});
		end
		link.frame(sp, dbl);
		repeat (20) @(posedge ref_clk);
		for (int i = 0; i < 128; i++) begin
			rd(9'(i));
			chk(rd_val, {8'h00, link.rx_mem[i]});
			chk(16'(link.oe_cap[i]), 16'(tsc[i / 16][i % 16]));
			if (tsc[i / 16][i % 16])
				chk(16'(link.tx_cap[i]), 16'(tx_exp[i]));
		end
		chk(16'(link.idle_bad), 16'h0000);
		$display("mode %0d done", mode);
	endtask
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 16'h0000;
		hdlc_tx_data = 4'h0;
		hdlc_tx_oe = 4'h0;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		rd(OFS_CTRL);
		chk(rd_val, 16'(CTRL_RESET));
		rd(9'h1ff);
		chk(rd_val, 16'h0000);
		run_mode(0, 0, 32);
		run_mode(1, 1, 64);
		run_mode(2, 0, 128);
		run_mode(11, 0, 256);
		rd(OFS_STATUS);
		chk(16'(rd_val[STAT_SYNCED_BIT]), 16'h0001);
		// pins handed to the hdlc unit follow its data and enable
		wr(OFS_CTRL, 16'h0010);
		repeat (4) begin
			hdlc_tx_data <= 4'(xs());
			hdlc_tx_oe <= 4'(xs());
			repeat (3) @(posedge ref_clk);
			chk(16'({serial_tx_line_oe, serial_tx_line_out, slot_tristate_out}),
				16'({hdlc_tx_oe, hdlc_tx_data, 4'h0}));
		end
		chk(16'(rx_overflow), 16'h0000);
		$display("hdlc owner done");
		finish_test();
	end
	// watchdog: the run needs about 360 us
	initial begin
		#385_000;
		errors++;
		finish_test();
	end
endmodule
`default_nettype wire
